// [core/bcc_regs.sv]
`timescale 1ns/100ps
`default_nettype none
`include "bcc_map.svh"

module bcc_regs #(
    parameter int ADDR_W          = 17,
    parameter int RAMP_BASE_CYCLES = `BCC_RAMP_BASE_CYC,
    parameter int SS_BASE_CYCLES   = `BCC_SS_BASE_CYC
) (
    input  wire logic                clk_in,
    input  wire logic                rst_b_in,
    input  wire logic [ADDR_W-1:0]   avs_address_in,
    input  wire logic                avs_read_in,
    input  wire logic                avs_write_in,
    input  wire logic [31:0]         avs_writedata_in,
    input  wire logic [3:0]          avs_byteenable_in,
    output logic      [31:0]         avs_readdata_out,
    output logic                     avs_waitrequest_out,
    input  wire logic                hwctl1_in,
    input  wire logic                hwctl2_in,
    input  wire logic                undervoltage_in,
    input  wire logic                highcurrent_cmp_in,
    input  wire logic                external_config_load_in,
    input  wire logic [1:0]          cfg_switch_frequency_in,
    input  wire logic [1:0]          cfg_output_capacitor_in,
    output logic                     irq_out,
    output logic                     conv_on_out,
    output logic [1:0]               conv_mode_out,
    output logic [6:0]               vout_code_out,
    output logic                     buck1_clock_phase_out,
    output logic [1:0]               buck1_switch_frequency_out,
    output logic [1:0]               buck1_output_capacitor_out,
    output logic                     discharge_out,
    output logic [2:0]               buck1_highcurrent_threshold_out,
    output logic                     buck1_highcurrent_detect_en_out,
    output logic                     softstart_active_out,
    output logic [2:0]               softstart_stage_out,
    output logic                     system_reset_req_out
);
    localparam int CW = 16;

    // refuse settings the counters cannot hold
    if (RAMP_BASE_CYCLES < 1 || RAMP_BASE_CYCLES * 4 >= (1 << CW))
        $error("ramp base count out of range");
    if (SS_BASE_CYCLES < 1 || SS_BASE_CYCLES * 8 >= (1 << CW))
        $error("soft-start base count out of range");
    if (ADDR_W < 17)
        $error("address too narrow for register map");

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [15:0] idx);
        hit = (a == ADDR_W'({idx, 2'b00}));
    endfunction : hit

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be,
                                          input logic [15:0] mask);
        logic [15:0] lanes;
        lanes = {{8{be[1]}}, {8{be[0]}}} & mask;
        merge = (old & ~lanes) | (wd[15:0] & lanes);
    endfunction : merge

    logic [15:0] ctrl1;
    logic [15:0] ctrl2;
    logic [15:0] ctrl3;
    logic [6:0]  buck1_normal_voltage;
    logic [6:0]  buck1_sleep_voltage;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_en;
    logic        bus_ack;
    logic [6:0]  vout;

    // pin synchronisers: three stages, change accepted when 2 and 3 agree
    logic [3:0] pin_raw;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] pin_q;
    assign pin_raw = {highcurrent_cmp_in, undervoltage_in, hwctl2_in,
                      hwctl1_in};
    for (genvar g = 0; g < 4; g++) begin : g_sync
        always_ff @(posedge clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                sync1[g] <= 1'b0;
                sync2[g] <= 1'b0;
                sync3[g] <= 1'b0;
                pin_q[g] <= 1'b0;
            end else begin
                sync1[g] <= pin_raw[g];
                sync2[g] <= sync1[g];
                sync3[g] <= sync2[g];
                if (sync2[g] == sync3[g]) begin
                    pin_q[g] <= sync3[g];
                end
            end
        end
    end

    // decoded fields
    bcc_pkg::bcc_ramp_type   ramp_rate;
    bcc_pkg::bcc_erract_type err_act;
    logic [1:0] hw_src;
    logic       hw_active;
    logic       detect_en;
    logic       hc_flag;
    logic       uv_flag;
    logic       uv_prev;
    logic       hc_prev;
    logic       uv_event;
    logic       hc_event;
    logic [6:0] target;
    logic       conv_on;

    assign ramp_rate = bcc_pkg::bcc_ramp_type'(ctrl1[`BCC_RATE_LSB +: 2]);
    assign err_act = bcc_pkg::bcc_erract_type'(ctrl2[`BCC_ERRACT_LSB +: 2]);
    assign hw_src = ctrl2[`BCC_HWSRC_LSB +: 2];
    // src 00 none, 01 input 1, 10 input 2, 11 either
    assign hw_active = (hw_src[0] & pin_q[0])
                     | (hw_src[1] & pin_q[1]);
    assign detect_en = ctrl2[`BCC_HCEN_BIT];
    assign hc_flag = detect_en & pin_q[3];
    assign uv_flag = pin_q[2];
    assign uv_event = uv_flag & ~uv_prev;
    assign hc_event = hc_flag & ~hc_prev;

    // voltage and mode follow hardware control, fall back on release
    assign target = (hw_active && ctrl2[`BCC_HWVSEL_BIT])
                  ? buck1_sleep_voltage
                  : buck1_normal_voltage;
    assign conv_mode_out = hw_active ? ctrl2[`BCC_HWMODE_LSB +: 2]
                         : ctrl3[`BCC_NMODE_LSB +: 2];
    assign conv_on = ctrl3[`BCC_EN_BIT]
                   & ~(hw_active && ctrl2[`BCC_HWMODE_LSB +: 2]
                       == bcc_pkg::bcc_mode_off);
    assign conv_on_out = conv_on;

    // outputs from register fields, plus discharge gated by conv_on, the ramped vout and the masked irq
    assign buck1_clock_phase_out = ctrl1[`BCC_PHASE_BIT];
    assign buck1_switch_frequency_out = ctrl1[`BCC_FREQ_LSB +: 2];
    assign buck1_output_capacitor_out = ctrl1[`BCC_CAP_LSB +: 2];
    assign discharge_out = ~conv_on & ctrl1[`BCC_FLOAT_BIT];
    assign buck1_highcurrent_threshold_out =
        ctrl2[`BCC_HCTHR_LSB +: 3];
    assign buck1_highcurrent_detect_en_out = detect_en;
    assign vout_code_out = vout;
    assign irq_out = |(irq_stat & irq_en);

    // bus: one wait cycle per access so read data comes from a flop
    logic bus_req;
    logic wr_take;
    assign bus_req = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = bus_req & ~bus_ack;
    assign wr_take = avs_write_in & bus_ack;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= bus_req & ~bus_ack;
        end
    end

    // read data captured on the wait cycle, stands at the accepting edge
    logic [15:0] next_rdata;
    always_comb begin
        next_rdata = 16'h0000;
        if (hit(avs_address_in, `BCC_IDX_CTRL1)) next_rdata = ctrl1;
        if (hit(avs_address_in, `BCC_IDX_CTRL2)) next_rdata = ctrl2;
        if (hit(avs_address_in, `BCC_IDX_CTRL3)) next_rdata = ctrl3;
        if (hit(avs_address_in, `BCC_IDX_NORMAL_V))
            next_rdata = {9'h000, buck1_normal_voltage};
        if (hit(avs_address_in, `BCC_IDX_SLEEP_V))
            next_rdata = {9'h000, buck1_sleep_voltage};
        if (hit(avs_address_in, `BCC_IDX_STATUS)) begin
            next_rdata[`BCC_STS_HC_BIT] = hc_flag;
            next_rdata[`BCC_STS_UV_BIT] = uv_flag;
            next_rdata[`BCC_STS_SS_BIT] = softstart_active_out;
        end
        if (hit(avs_address_in, `BCC_IDX_IRQ_STAT))
            next_rdata = {14'h0000, irq_stat};
        if (hit(avs_address_in, `BCC_IDX_IRQ_EN))
            next_rdata = {14'h0000, irq_en};
        if (hit(avs_address_in, `BCC_IDX_VOUT))
            next_rdata = {9'h000, vout};
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (avs_read_in && !bus_ack) begin
            avs_readdata_out <= {16'h0000, next_rdata};
        end
    end

    // control 1: software bits by mask, freq and cap only by config load
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl1 <= `BCC_CTRL1_RST;
        end else begin
            if (wr_take && hit(avs_address_in, `BCC_IDX_CTRL1)) begin
                ctrl1 <= merge(ctrl1, avs_writedata_in, avs_byteenable_in,
                               `BCC_CTRL1_SW_MASK);
            end
            if (external_config_load_in) begin
                ctrl1[`BCC_FREQ_LSB +: 2] <= cfg_switch_frequency_in;
                ctrl1[`BCC_CAP_LSB +: 2] <= cfg_output_capacitor_in;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl2 <= `BCC_CTRL2_RST;
        end else if (wr_take && hit(avs_address_in, `BCC_IDX_CTRL2)) begin
            ctrl2 <= merge(ctrl2, avs_writedata_in, avs_byteenable_in,
                           `BCC_CTRL2_SW_MASK);
        end
    end

    // control 3: an undervoltage shutdown clears the enable and beats a write
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl3 <= `BCC_CTRL3_RST;
        end else if (uv_event && err_act == bcc_pkg::bcc_err_conv_off) begin
            ctrl3[`BCC_EN_BIT] <= 1'b0;
        end else if (wr_take && hit(avs_address_in, `BCC_IDX_CTRL3)) begin
            ctrl3 <= merge(ctrl3, avs_writedata_in, avs_byteenable_in,
                           `BCC_CTRL3_SW_MASK);
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            buck1_normal_voltage <= `BCC_VSEL_RST;
            buck1_sleep_voltage <= `BCC_VSEL_RST;
        end else if (wr_take && avs_byteenable_in[0]) begin
            if (hit(avs_address_in, `BCC_IDX_NORMAL_V))
                buck1_normal_voltage <= avs_writedata_in[6:0];
            if (hit(avs_address_in, `BCC_IDX_SLEEP_V))
                buck1_sleep_voltage <= avs_writedata_in[6:0];
        end
    end

    // system reset request is a single pulse per undervoltage event while the error action is bcc_err_sys_reset
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            system_reset_req_out <= 1'b0;
        end else begin
            system_reset_req_out <= uv_event
                && err_act == bcc_pkg::bcc_err_sys_reset;
        end
    end

    // sticky events; a new event in the clearing cycle stays set
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            uv_prev <= 1'b0;
            hc_prev <= 1'b0;
            irq_stat <= 2'b00;
            irq_en <= 2'b00;
        end else begin
            uv_prev <= uv_flag;
            hc_prev <= hc_flag;
            if (wr_take && hit(avs_address_in, `BCC_IDX_IRQ_EN)
                && avs_byteenable_in[0])
                irq_en <= avs_writedata_in[1:0];
            irq_stat <= (irq_stat
                & ~((wr_take && hit(avs_address_in, `BCC_IDX_IRQ_CLR)
                     && avs_byteenable_in[0]) ? avs_writedata_in[1:0] : 2'b00))
                | {hc_event, uv_event};
        end
    end

    // voltage ramp: one code per period toward the target, straight to the target at bcc_ramp_now
    logic [CW-1:0] ramp_cnt;
    logic [CW-1:0] ramp_period;
    always_comb begin
        unique case (ramp_rate)
            bcc_pkg::bcc_ramp_32us: ramp_period = CW'(RAMP_BASE_CYCLES * 4);
            bcc_pkg::bcc_ramp_16us: ramp_period = CW'(RAMP_BASE_CYCLES * 2);
            bcc_pkg::bcc_ramp_8us:  ramp_period = CW'(RAMP_BASE_CYCLES);
            bcc_pkg::bcc_ramp_now:  ramp_period = CW'(1);
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            vout <= `BCC_VSEL_RST;
            ramp_cnt <= '0;
        end else if (ramp_rate == bcc_pkg::bcc_ramp_now) begin
            vout <= target;
            ramp_cnt <= '0;
        end else if (vout == target) begin
            ramp_cnt <= '0;
        end else if (ramp_cnt >= ramp_period - CW'(1)) begin
            ramp_cnt <= '0;
            vout <= (target > vout) ? vout + 7'h01
                                    : vout - 7'h01;
        end else begin
            ramp_cnt <= ramp_cnt + CW'(1);
        end
    end

    // soft start: eight stages from each enable, aborted when disabled
    bcc_pkg::bcc_ss_type ss_state;
    logic [CW-1:0] ss_cnt;
    logic [CW-1:0] ss_period;
    logic          conv_on_prev;
    assign ss_period = CW'(SS_BASE_CYCLES) << ctrl1[`BCC_SS_LSB +: 2];
    assign softstart_active_out = (ss_state == bcc_pkg::bcc_ss_run);

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ss_state <= bcc_pkg::bcc_ss_idle;
            ss_cnt <= '0;
            softstart_stage_out <= 3'h0;
            conv_on_prev <= 1'b0;
        end else begin
            conv_on_prev <= conv_on;
            unique case (ss_state)
                bcc_pkg::bcc_ss_idle: begin
                    if (conv_on && !conv_on_prev) begin
                        ss_state <= bcc_pkg::bcc_ss_run;
                        ss_cnt <= '0;
                        softstart_stage_out <= 3'h0;
                    end
                end
                bcc_pkg::bcc_ss_run: begin
                    if (!conv_on) begin
                        ss_state <= bcc_pkg::bcc_ss_idle;
                    end else if (ss_cnt >= ss_period - CW'(1)) begin
                        ss_cnt <= '0;
                        if (softstart_stage_out == 3'(`BCC_SS_STAGES - 1))
                            ss_state <= bcc_pkg::bcc_ss_idle;
                        else
                            softstart_stage_out <= softstart_stage_out + 3'h1;
                    end else begin
                        ss_cnt <= ss_cnt + CW'(1);
                    end
                end
            endcase
        end
    end
endmodule : bcc_regs

`default_nettype wire

// [core/bcc_map.svh]
`ifndef BCC_MAP_SVH
`define BCC_MAP_SVH

// register indices; byte address is four times the index
`define BCC_IDX_CTRL1      16'h4056
`define BCC_IDX_CTRL2      16'h4057
`define BCC_IDX_CTRL3      16'h4060
`define BCC_IDX_NORMAL_V   16'h4061
`define BCC_IDX_SLEEP_V    16'h4062
`define BCC_IDX_STATUS     16'h4063
`define BCC_IDX_IRQ_STAT   16'h4064
`define BCC_IDX_IRQ_CLR    16'h4065
`define BCC_IDX_IRQ_EN     16'h4066
`define BCC_IDX_VOUT       16'h4067

// control 1 field positions
`define BCC_RATE_LSB       14
`define BCC_PHASE_BIT      12
`define BCC_FREQ_LSB       8
`define BCC_FLOAT_BIT      7
`define BCC_SS_LSB         4
`define BCC_CAP_LSB        0
`define BCC_CTRL1_SW_MASK  16'hd0b0
`define BCC_CTRL1_RST      16'h8000

// control 2 field positions
`define BCC_ERRACT_LSB     14
`define BCC_HWSRC_LSB      11
`define BCC_HWVSEL_BIT     10
`define BCC_HWMODE_LSB     8
`define BCC_HCTHR_LSB      4
`define BCC_HCEN_BIT       0
`define BCC_CTRL2_SW_MASK  16'hdf71
`define BCC_CTRL2_RST      16'h0300

// control 3: converter enable and normal mode
`define BCC_EN_BIT         0
`define BCC_NMODE_LSB      8
`define BCC_CTRL3_SW_MASK  16'h0301
`define BCC_CTRL3_RST      16'h0100

// status and interrupt bits
`define BCC_STS_UV_BIT     0
`define BCC_STS_SS_BIT     4
`define BCC_STS_HC_BIT     8
`define BCC_IRQ_UV_BIT     0
`define BCC_IRQ_HC_BIT     1
`define BCC_VSEL_RST       7'h00

// timing
`define BCC_CLK_MHZ        20
`define BCC_RAMP_BASE_US   8
`define BCC_SS_BASE_US     32
`define BCC_RAMP_BASE_CYC  (`BCC_RAMP_BASE_US * `BCC_CLK_MHZ)
`define BCC_SS_BASE_CYC    (`BCC_SS_BASE_US * `BCC_CLK_MHZ)
`define BCC_SS_STAGES      8

`endif

// [core/bcc_pkg.sv]
package bcc_pkg;
    typedef enum logic [1:0] {
        bcc_ramp_32us, bcc_ramp_16us, bcc_ramp_8us, bcc_ramp_now
    } bcc_ramp_type;
    typedef enum logic [1:0] {
        bcc_err_ignore, bcc_err_conv_off, bcc_err_sys_reset, bcc_err_rsvd
    } bcc_erract_type;
    typedef enum logic [1:0] {
        bcc_mode_fccm, bcc_mode_off, bcc_mode_ldo, bcc_mode_hyst
    } bcc_mode_type;
    typedef enum logic {bcc_ss_idle, bcc_ss_run} bcc_ss_type;
endpackage : bcc_pkg

// [tb/bcc_regs_chk.sv]
`timescale 1ns/100ps
`default_nettype none
// watches bus handshake, pin-driven outputs and register-fed outputs
module bcc_regs_chk (
    input wire logic       clk_in,
    input wire logic       rst_b_in,
    input wire logic       avs_read_in,
    input wire logic       avs_write_in,
    input wire logic       avs_waitrequest_out,
    input wire logic       undervoltage_in,
    input wire logic       highcurrent_cmp_in,
    input wire logic       external_config_load_in,
    input wire logic       irq_out,
    input wire logic       conv_on_out,
    input wire logic [6:0] vout_code_out,
    input wire logic       buck1_clock_phase_out,
    input wire logic [1:0] buck1_switch_frequency_out,
    input wire logic [1:0] buck1_output_capacitor_out,
    input wire logic       discharge_out,
    input wire logic [2:0] buck1_highcurrent_threshold_out,
    input wire logic       buck1_highcurrent_detect_en_out,
    input wire logic       softstart_active_out,
    input wire logic [2:0] softstart_stage_out,
    input wire logic       system_reset_req_out
);
    default clocking dc @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // a write lands only at the edge where waitrequest is low
    wire logic wr_acc = avs_write_in & ~avs_waitrequest_out;
    chk_wait_first: assert property ($rose(avs_read_in | avs_write_in)
        |-> avs_waitrequest_out) else $error("no wait on first cycle");
    chk_wait_one: assert property ((avs_read_in | avs_write_in) &&
        avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("answer later than one wait");
    chk_ramp_hold: assert property (
        $changed(vout_code_out) |=> $stable(vout_code_out))
        else $error("voltage code moved on consecutive edges");
    chk_ss_next: assert property (
        softstart_active_out && $past(softstart_active_out) &&
        $changed(softstart_stage_out) |->
        softstart_stage_out == $past(softstart_stage_out) + 3'h1)
        else $error("soft-start stage skipped");
    chk_ss_dwell: assert property (
        $changed(softstart_stage_out) |=> $stable(softstart_stage_out))
        else $error("soft-start stage too short");
    chk_phase_sw: assert property (
        $changed(buck1_clock_phase_out) |-> $past(wr_acc))
        else $error("phase changed without a write");
    chk_freq_cfg: assert property (
        $changed({buck1_switch_frequency_out, buck1_output_capacitor_out})
        |-> $past(external_config_load_in))
        else $error("frequency or capacitor changed without load");
    chk_hc_sw: assert property (
        $changed({buck1_highcurrent_threshold_out,
        buck1_highcurrent_detect_en_out}) |-> $past(wr_acc))
        else $error("threshold changed without a write");
    chk_float_off: assert property (
        discharge_out |-> !conv_on_out)
        else $error("discharge while converter on");
    chk_rst_pulse: assert property (
        system_reset_req_out |=> !system_reset_req_out)
        else $error("reset request longer than one cycle");
    chk_rst_cause: assert property (
        system_reset_req_out |-> $past(undervoltage_in, 4))
        else $error("reset request without undervoltage");
    chk_irq_cause: assert property (
        $rose(irq_out) |-> $past(undervoltage_in) ||
        $past(highcurrent_cmp_in) || $past(wr_acc))
        else $error("interrupt without a cause");
    cover property (system_reset_req_out);
    cover property ($rose(irq_out));
    cover property (softstart_active_out && $changed(softstart_stage_out));
endmodule : bcc_regs_chk
`default_nettype wire

// [tb/bcc_regs_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "bcc_map.svh"
`define CHK(g, e) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("CHECK FAILED at %0t: value mismatch", $time); \
    end \
end
module bcc_regs_bench;
    logic        clk_in = 1'h0;
    logic        rst_b_in = 1'h0;
    logic [16:0] avs_address_in = 17'h0;
    logic        avs_read_in = 1'h0;
    logic        avs_write_in = 1'h0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [3:0]  avs_byteenable_in = 4'hf;
    logic        hwctl1_in = 1'h0;
    logic        hwctl2_in = 1'h0;
    logic        undervoltage_in = 1'h0;
    logic        highcurrent_cmp_in = 1'h0;
    logic        external_config_load_in = 1'h0;
    logic [1:0]  cfg_switch_frequency_in = 2'h0;
    logic [1:0]  cfg_output_capacitor_in = 2'h0;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out, irq_out, conv_on_out, discharge_out;
    logic [1:0]  conv_mode_out, buck1_switch_frequency_out;
    logic [2:0]  buck1_highcurrent_threshold_out;
    logic [6:0]  vout_code_out;
    logic        softstart_active_out, system_reset_req_out;
    logic [15:0] exp_q[$], msk_q[$];
    logic [31:0] r;
    int          err_total = 0, total_checks = 0, cyc = 0, a;
    int          seed = 32'h9ba0;
    int          ss_cyc = 0, rst_reqs = 0;
    // short base counts keep ramp and soft-start runs brief
    bcc_regs #(.RAMP_BASE_CYCLES(2), .SS_BASE_CYCLES(2)) bcc_regs_inst (
        .clk_in, .rst_b_in, .avs_address_in, .avs_read_in, .avs_write_in,
        .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
        .avs_waitrequest_out, .hwctl1_in, .hwctl2_in, .undervoltage_in,
        .highcurrent_cmp_in, .external_config_load_in,
        .cfg_switch_frequency_in, .cfg_output_capacitor_in, .irq_out,
        .conv_on_out, .conv_mode_out, .vout_code_out,
        .buck1_clock_phase_out(), .buck1_switch_frequency_out,
        .buck1_output_capacitor_out(), .discharge_out,
        .buck1_highcurrent_threshold_out,
        .buck1_highcurrent_detect_en_out(), .softstart_active_out,
        .softstart_stage_out(), .system_reset_req_out
    );
    // 20 MHz clock
    always #25 clk_in = ~clk_in;
    task automatic summarize();
        if (err_total == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    // hang guard: the whole sequence needs under 500 cycles
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end
    // one transfer held until waitrequest is seen low; reads leave a note
    task automatic bus(input logic w, input logic [15:0] idx,
                       input logic [15:0] d, input logic [15:0] m,
                       input logic [15:0] e);
        avs_address_in   <= {idx[14:0], 2'h0};
        avs_writedata_in <= {16'h0, d};
        avs_write_in     <= w;
        avs_read_in      <= ~w;
        if (!w) begin
            exp_q.push_back(e);
            msk_q.push_back(m);
        end
        @(posedge clk_in);
        while (avs_waitrequest_out !== 1'h0) begin
            @(posedge clk_in);
        end
        avs_write_in <= 1'h0;
        avs_read_in  <= 1'h0;
        @(posedge clk_in);
    endtask : bus
    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        bus(1'h1, idx, d, 16'h0, 16'h0);
    endtask : wr
    task automatic rd(input logic [15:0] idx, input logic [15:0] m,
                      input logic [15:0] e);
        bus(1'h0, idx, 16'h0, m, e);
    endtask : rd
    // read data stands at the accepting edge; upper half must read zero
    always @(posedge clk_in) begin
        if (avs_read_in && avs_waitrequest_out === 1'h0) begin
            `CHK(avs_readdata_out & {16'hffff, msk_q[0]}, {16'h0, exp_q[0]})
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end
    // soft-start cycles and reset pulses, totalled for later checks
    always @(posedge clk_in) begin
        ss_cyc <= ss_cyc + softstart_active_out;
        rst_reqs <= rst_reqs + system_reset_req_out;
    end
    // main sequence
    initial begin
        repeat (6) @(posedge clk_in);
        rst_b_in <= 1'h1;
        @(posedge clk_in);
        rd(`BCC_IDX_CTRL1, 16'hffff, 16'h8000);
        rd(`BCC_IDX_CTRL2, 16'hffff, 16'h0300);
        wr(16'h4070, 16'hffff);
        rd(16'h4070, 16'hffff, 16'h0000);
        // frequency and capacitor bits must ignore software
        wr(`BCC_IDX_CTRL1, 16'hffff);
        rd(`BCC_IDX_CTRL1, 16'hffff, 16'hd0b0);
        for (a = 0; a < 4; a++) begin
            r = $random(seed);
            wr(`BCC_IDX_CTRL2, r[15:0]);
            rd(`BCC_IDX_CTRL2, 16'hffff, r[15:0] & 16'hdf71);
            `CHK(buck1_highcurrent_threshold_out, r[6:4])
        end
        avs_byteenable_in <= 4'h1;
        wr(`BCC_IDX_CTRL2, 16'h0000);
        avs_byteenable_in <= 4'hf;
        rd(`BCC_IDX_CTRL2, 16'hffff, r[15:0] & 16'hdf00);
        // a configuration load is the only way into those bits
        for (a = 0; a < 4; a++) begin
            r = $random(seed);
            cfg_switch_frequency_in <= r[1:0];
            cfg_output_capacitor_in <= r[3:2];
            external_config_load_in <= 1'h1;
            @(posedge clk_in);
            external_config_load_in <= 1'h0;
            repeat (2) @(posedge clk_in);
            `CHK(buck1_switch_frequency_out, r[1:0])
            rd(`BCC_IDX_CTRL1, 16'h0303,
               {6'h0, r[1:0], 6'h0, r[3:2]});
        end
        // stepped ramp, then an immediate jump 64 codes away
        wr(`BCC_IDX_CTRL1, 16'h8020);
        wr(`BCC_IDX_NORMAL_V, 16'h0010);
        wr(`BCC_IDX_CTRL3, 16'h0001);
        // 15 cycles after the target landed: seven 2-cycle steps
        repeat (11) @(posedge clk_in);
        `CHK(vout_code_out, 7'h07)
        repeat (89) @(posedge clk_in);
        // stage code 10: eight stages of four base counts each
        `CHK(ss_cyc, `BCC_SS_STAGES * 8)
        rd(`BCC_IDX_VOUT, 16'h007f, 16'h0010);
        wr(`BCC_IDX_CTRL1, 16'hc000);
        wr(`BCC_IDX_NORMAL_V, 16'h0050);
        rd(`BCC_IDX_VOUT, 16'h007f, 16'h0050);
        // flag follows the comparator only while detection is on
        wr(`BCC_IDX_CTRL2, 16'h0071);
        highcurrent_cmp_in <= 1'h1;
        repeat (8) @(posedge clk_in);
        rd(`BCC_IDX_STATUS, 16'h0101, 16'h0100);
        wr(`BCC_IDX_CTRL2, 16'h0070);
        rd(`BCC_IDX_STATUS, 16'h0100, 16'h0000);
        highcurrent_cmp_in <= 1'h0;
        wr(`BCC_IDX_IRQ_CLR, 16'h0003);
        // every error action, ignore included, still interrupts
        wr(`BCC_IDX_IRQ_EN, 16'h0001);
        for (a = 0; a < 4; a++) begin
            wr(`BCC_IDX_CTRL2, {a[1:0], 14'h0300});
            wr(`BCC_IDX_CTRL3, 16'h0001);
            undervoltage_in <= 1'h1;
            repeat (8) @(posedge clk_in);
            `CHK(irq_out, 1'h1)
            rd(`BCC_IDX_STATUS, 16'h0001, 16'h0001);
            rd(`BCC_IDX_CTRL3, 16'h0001, {15'h0, a != 1});
            undervoltage_in <= 1'h0;
            repeat (8) @(posedge clk_in);
            wr(`BCC_IDX_IRQ_CLR, 16'h0001);
            rd(`BCC_IDX_IRQ_STAT, 16'h0001, 16'h0000);
        end
        // only action 10 asks for a system reset
        `CHK(rst_reqs, 1)
        // masked event stays sticky but keeps the line low
        wr(`BCC_IDX_IRQ_EN, 16'h0000);
        undervoltage_in <= 1'h1;
        repeat (8) @(posedge clk_in);
        `CHK(irq_out, 1'h0)
        rd(`BCC_IDX_IRQ_STAT, 16'h0001, 16'h0001);
        undervoltage_in <= 1'h0;
        wr(`BCC_IDX_IRQ_CLR, 16'h0001);
        // hardware control swaps in sleep voltage and its own mode
        wr(`BCC_IDX_CTRL1, 16'hc080);
        wr(`BCC_IDX_SLEEP_V, 16'h0020);
        wr(`BCC_IDX_CTRL3, 16'h0001);
        wr(`BCC_IDX_CTRL2, 16'h0e00);
        hwctl1_in <= 1'h1;
        repeat (8) @(posedge clk_in);
        `CHK(conv_mode_out, 2'h2)
        rd(`BCC_IDX_VOUT, 16'h007f, 16'h0020);
        hwctl1_in <= 1'h0;
        repeat (8) @(posedge clk_in);
        `CHK(conv_mode_out, 2'h0)
        rd(`BCC_IDX_VOUT, 16'h007f, 16'h0050);
        wr(`BCC_IDX_CTRL2, 16'h1100);
        hwctl1_in <= 1'h1;
        repeat (8) @(posedge clk_in);
        `CHK(conv_on_out, 1'h1)
        hwctl1_in <= 1'h0;
        hwctl2_in <= 1'h1;
        wr(`BCC_IDX_CTRL2, 16'h1900);
        repeat (8) @(posedge clk_in);
        `CHK(conv_on_out, 1'h0)
        `CHK(discharge_out, 1'h1)
        summarize();
    end
endmodule : bcc_regs_bench
bind bcc_regs bcc_regs_chk bcc_regs_chk_inst (
    .clk_in, .rst_b_in, .avs_read_in, .avs_write_in, .avs_waitrequest_out,
    .undervoltage_in, .highcurrent_cmp_in, .external_config_load_in,
    .irq_out, .conv_on_out, .vout_code_out, .buck1_clock_phase_out,
    .buck1_switch_frequency_out, .buck1_output_capacitor_out,
    .discharge_out, .buck1_highcurrent_threshold_out,
    .buck1_highcurrent_detect_en_out, .softstart_active_out,
    .softstart_stage_out, .system_reset_req_out
);
`default_nettype wire
